// ==== shared/uis_pkg.sv ====
/*
 * Shared constants and types for the UART interrupt summary and receive
 * line status block: register offsets, bit positions, reset values and
 * the per-character status carrier.
 * Assumes one 8-bit register port driven by the serial control front end.
 */
package uis_pkg;

    // Register offsets on the 8-bit control port
    localparam logic [7:0] OFS_IRQ_SUMMARY = 8'h02;
    localparam logic [7:0] OFS_LINE_ERR_EN = 8'h03;
    localparam logic [7:0] OFS_LINE_STATUS = 8'h04;

    // Reset values
    localparam logic [7:0] RST_IRQ_SUMMARY = 8'h00;
    localparam logic [7:0] RST_LINE_ERR_EN = 8'h00;
    localparam logic [7:0] RST_ZERO = 8'h00;

    // Summary status bit positions
    localparam int ISR_LINE_ERR = 0;
    localparam int ISR_SPECIAL = 1;
    localparam int ISR_STATUS = 2;
    localparam int ISR_RX_LEVEL = 3;
    localparam int ISR_TX_LEVEL = 4;
    localparam int ISR_TX_EMPTY = 5;
    localparam int ISR_RX_EMPTY = 6;
    localparam int ISR_CTS_CHG = 7;

    // Line status bit positions (enable register uses bits 5..0 alike)
    localparam int LSR_STALE = 0;
    localparam int LSR_OVERRUN = 1;
    localparam int LSR_PARITY = 2;
    localparam int LSR_FRAMING = 3;
    localparam int LSR_BREAK = 4;
    localparam int LSR_NOISE = 5;
    localparam int LSR_CTS = 7;

    // Secondary mode control bit positions
    localparam int MODE_RX_LEVEL_INV = 2;
    localparam int MODE_RX_EMPTY_INV = 3;
    localparam int MODE_MULTIDROP = 6;

    // Width of the six line-error enables and the special causes
    localparam int LINE_ERR_BITS = 6;
    localparam int SPECIAL_BITS = 6;
    localparam int STATUS_BITS = 8;

    // FIFO level width (0..128 words)
    localparam int LEVEL_W = 8;

    // Stale data counter reset value
    localparam logic [7:0] STALE_CNT_RST = 8'h00;

    // Edges after reset before the clear-to-send chain holds pin values
    localparam logic [1:0] CTS_FILL_DONE = 2'h3;

    // Status that travels with each received character
    typedef struct packed {
        logic noise;
        logic brk;
        logic framing;
        logic parity;      // Parity mismatch, or ninth bit in multidrop
    } uis_char_status_t;

endpackage

// ==== core/uis_irq_line_status.sv ====
/*
 * Interrupt summary register, line error enable register and receive line
 * status register of one UART channel, plus the active-low interrupt pin.
 * Assumes the serial control front end issues one-cycle read and write
 * strobes with an 8-bit offset, and that FIFOs, receiver, mode and enable
 * registers kept elsewhere present their state on plain inputs.
 */
`timescale 1ns/1ps

module uis_irq_line_status (
    input wire logic sys_clk,
    input wire logic rst_b,
    // Register port from the serial control front end
    input wire logic [7:0] reg_addr,
    input wire logic reg_rd,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    // Clear-to-send pin, asynchronous
    input wire logic cts_pin,
    // Receive side
    input wire logic rx_char_valid,
    input wire logic rx_fifo_full,
    input wire logic [7:0] rx_fifo_level,
    input wire logic rhr_read,
    input wire uis_pkg::uis_char_status_t rhr_status,
    input wire logic stale_tick,
    input wire logic [7:0] stale_data_limit,
    // Transmit side
    input wire logic [7:0] tx_fifo_level,
    // Configuration held elsewhere
    input wire logic [7:0] fifo_level_thresholds,
    input wire logic [7:0] secondary_mode_control,
    input wire logic [7:0] irq_out_enable_reg,
    input wire logic [5:0] special_char_cause_reg,
    input wire logic [5:0] special_char_route_enable,
    input wire logic [7:0] status_source_reg,
    input wire logic [7:0] status_route_enable,
    // Interrupt pin
    output logic irq_b
);

    // Register state
    logic [7:0] isr_reg;
    logic [7:0] isr_next;
    logic [5:0] line_err_en_reg;
    logic [5:0] line_err_en_next;
    uis_pkg::uis_char_status_t char_stat_reg;
    uis_pkg::uis_char_status_t char_stat_next;
    logic overrun_reg;
    logic overrun_next;
    logic stale_reg;
    logic stale_next;
    logic [7:0] stale_cnt_reg;
    logic [7:0] stale_cnt_next;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;
    // Clear-to-send synchroniser and filtered level
    logic [2:0] cts_sync_reg;
    logic [2:0] cts_sync_next;
    // Counts the edges until the pin has reached the last stage
    logic [1:0] cts_fill_reg;
    logic [1:0] cts_fill_next;
    logic cts_level_reg, cts_level_next;
    logic cts_valid_reg, cts_valid_next;
    // Edge detectors for event-type sources
    logic tx_empty_prev_reg, tx_empty_prev_next;
    logic rx_lvl_prev_reg, rx_lvl_prev_next;

    logic isr_read;
    logic [7:0] lsr_view;
    logic [5:0] line_flags;
    logic cts_change;
    logic tx_empty_now;
    logic tx_lvl_hit;
    logic rx_lvl_cond;
    logic [7:0] tx_trig;
    logic [7:0] rx_trig;
    logic rx_fifo_empty;
    logic [7:0] set_bits;

    assign isr_read = reg_rd && (reg_addr == uis_pkg::OFS_IRQ_SUMMARY);

    // Trigger levels live in the two nibbles of the threshold register
    assign tx_trig = {4'h0, fifo_level_thresholds[3:0]};
    assign rx_trig = {4'h0, fifo_level_thresholds[7:4]};
    assign rx_fifo_empty = (rx_fifo_level == 8'h00);
    assign tx_empty_now = (tx_fifo_level == 8'h00);
    assign tx_lvl_hit = (tx_fifo_level >= tx_trig);
    assign rx_lvl_cond = (rx_fifo_level >= rx_trig)
        ^ secondary_mode_control[uis_pkg::MODE_RX_LEVEL_INV];

    // Clear-to-send: a change counts once stages two and three agree.
    // Nothing is judged until the pin has reached the third stage, so
    // the cleared chain after reset never poses as a pin level and no
    // false change follows reset.
    always_comb begin
        cts_sync_next = {cts_sync_reg[1:0], cts_pin};
        cts_fill_next = cts_fill_reg;
        if (cts_fill_reg != uis_pkg::CTS_FILL_DONE) begin
            cts_fill_next = cts_fill_reg + 2'h1;
        end
        cts_level_next = cts_level_reg;
        cts_valid_next = cts_valid_reg;
        cts_change = 1'b0;
        if (cts_fill_reg == uis_pkg::CTS_FILL_DONE
            && cts_sync_reg[1] == cts_sync_reg[2]) begin
            cts_level_next = cts_sync_reg[2];
            cts_valid_next = 1'b1;
            // First settle after reset is a level, not a transition
            cts_change = cts_valid_reg
                && (cts_sync_reg[2] != cts_level_reg);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            cts_sync_reg <= 3'h0;
            cts_fill_reg <= 2'h0;
            cts_level_reg <= 1'b0;
            cts_valid_reg <= 1'b0;
        end else begin
            cts_sync_reg <= cts_sync_next;
            cts_fill_reg <= cts_fill_next;
            cts_level_reg <= cts_level_next;
            cts_valid_reg <= cts_valid_next;
        end
    end

    // Per-character line flags latch when a word leaves the FIFO; overrun sets when a word meets a full FIFO
    always_comb begin
        char_stat_next = char_stat_reg;
        overrun_next = overrun_reg;
        if (rhr_read) begin
            // Each read replaces the flags, so an error-free word clears
            // them and a break clears after the next word is read
            char_stat_next = rhr_status;
            overrun_next = 1'b0;
        end
        // Set wins over the read that would clear it
        if (rx_char_valid && rx_fifo_full) begin
            overrun_next = 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            char_stat_reg <= '0;
            overrun_reg <= 1'b0;
        end else begin
            char_stat_reg <= char_stat_next;
            overrun_reg <= overrun_next;
        end
    end

    // Stale data timer counts ticks while data waits in the FIFO
    always_comb begin
        stale_cnt_next = stale_cnt_reg;
        stale_next = stale_reg;
        if (rhr_read || rx_char_valid) begin
            stale_cnt_next = uis_pkg::STALE_CNT_RST;
            stale_next = 1'b0;
        end else if (stale_data_limit == 8'h00 || rx_fifo_empty) begin
            // Zero limit disables the flag altogether
            stale_cnt_next = uis_pkg::STALE_CNT_RST;
            stale_next = 1'b0;
        end else if (stale_tick && !stale_reg) begin
            // Counter saturates at the limit, so no wrap is possible
            if (stale_cnt_reg >= stale_data_limit) begin
                stale_next = 1'b1;
            end else begin
                stale_cnt_next = stale_cnt_reg + 8'h01;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            stale_cnt_reg <= uis_pkg::STALE_CNT_RST;
            stale_reg <= 1'b0;
        end else begin
            stale_cnt_reg <= stale_cnt_next;
            stale_reg <= stale_next;
        end
    end

    // Line status as software sees it
    always_comb begin
        lsr_view = uis_pkg::RST_ZERO;
        lsr_view[uis_pkg::LSR_CTS] = cts_level_reg;
        lsr_view[uis_pkg::LSR_NOISE] = char_stat_reg.noise;
        lsr_view[uis_pkg::LSR_BREAK] = char_stat_reg.brk;
        lsr_view[uis_pkg::LSR_FRAMING] = char_stat_reg.framing;
        // Ninth bit comes through the same carrier field in multidrop
        lsr_view[uis_pkg::LSR_PARITY] = char_stat_reg.parity;
        lsr_view[uis_pkg::LSR_OVERRUN] = overrun_reg;
        lsr_view[uis_pkg::LSR_STALE] = stale_reg;
    end

    assign line_flags = lsr_view[5:0];

    // Event sources feeding the summary register
    always_comb begin
        set_bits = 8'h00;
        set_bits[uis_pkg::ISR_LINE_ERR] =
            |(line_flags & line_err_en_reg);
        set_bits[uis_pkg::ISR_SPECIAL] =
            |(special_char_cause_reg & special_char_route_enable);
        set_bits[uis_pkg::ISR_STATUS] =
            |(status_source_reg & status_route_enable);
        set_bits[uis_pkg::ISR_RX_LEVEL] =
            rx_lvl_cond && !rx_lvl_prev_reg;
        set_bits[uis_pkg::ISR_TX_LEVEL] = tx_lvl_hit;
        set_bits[uis_pkg::ISR_TX_EMPTY] =
            tx_empty_now && !tx_empty_prev_reg;
        set_bits[uis_pkg::ISR_RX_EMPTY] = rx_fifo_empty
            ^ secondary_mode_control[uis_pkg::MODE_RX_EMPTY_INV];
        set_bits[uis_pkg::ISR_CTS_CHG] = cts_change;
    end

    // Summary register: read clears, a same-cycle event still lands
    always_comb begin
        isr_next = isr_reg;
        if (isr_read) begin
            isr_next = 8'h00;
        end
        if (!tx_lvl_hit) begin
            isr_next[uis_pkg::ISR_TX_LEVEL] = 1'b0;
        end
        // Pin enables take no part here
        isr_next = isr_next | set_bits;
        tx_empty_prev_next = tx_empty_now;
        rx_lvl_prev_next = rx_lvl_cond;
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            isr_reg <= uis_pkg::RST_IRQ_SUMMARY;
            tx_empty_prev_reg <= 1'b1;
            rx_lvl_prev_reg <= 1'b0;
        end else begin
            isr_reg <= isr_next;
            tx_empty_prev_reg <= tx_empty_prev_next;
            rx_lvl_prev_reg <= rx_lvl_prev_next;
        end
    end

    // Line error enable register and read data
    always_comb begin
        line_err_en_next = line_err_en_reg;
        if (reg_wr && reg_addr == uis_pkg::OFS_LINE_ERR_EN) begin
            line_err_en_next = reg_wdata[5:0];
        end
        rdata_next = rdata_reg;
        if (reg_rd) begin
            case (reg_addr)
                uis_pkg::OFS_IRQ_SUMMARY: rdata_next = isr_reg;
                uis_pkg::OFS_LINE_ERR_EN:
                    rdata_next = {2'b00, line_err_en_reg};
                // Reading line status leaves every flag in place
                uis_pkg::OFS_LINE_STATUS: rdata_next = lsr_view;
                default: rdata_next = uis_pkg::RST_ZERO;
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            line_err_en_reg <= uis_pkg::RST_LINE_ERR_EN[5:0];
            rdata_reg <= uis_pkg::RST_ZERO;
        end else begin
            line_err_en_reg <= line_err_en_next;
            rdata_reg <= rdata_next;
        end
    end

    assign reg_rdata = rdata_reg;

    // Pin looks at the next summary value so a clearing read drops it
    // in the read cycle itself instead of one cycle late
    assign irq_b = ~|(isr_next & irq_out_enable_reg);

endmodule

// ==== bench/uis_irq_monitor.sv ====
/* Assertion checker for the interrupt summary and line status block.
   Sees only top-level ports; bound from the bench top file. */
`timescale 1ns/1ps
module uis_irq_monitor (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic [7:0] reg_addr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic cts_pin,
    input wire logic rx_char_valid,
    input wire logic rx_fifo_full,
    input wire logic rhr_read,
    input wire uis_pkg::uis_char_status_t rhr_status,
    input wire logic [7:0] irq_out_enable_reg,
    input wire logic [5:0] special_char_cause_reg,
    input wire logic [5:0] special_char_route_enable,
    input wire logic irq_b
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    logic [7:0] en;
    logic spc, rd2, rd3, rd4, cts_last;
    logic [3:0] cts_quiet;
    // Short names for the qualifiers used below
    assign en = irq_out_enable_reg;
    assign spc = |(special_char_cause_reg & special_char_route_enable);
    assign rd2 = reg_rd && reg_addr == 8'h02;
    assign rd3 = reg_rd && reg_addr == 8'h03;
    assign rd4 = reg_rd && reg_addr == 8'h04;
    // Pin quiet time; the synchroniser needs a few edges to settle
    always_ff @(posedge sys_clk) begin
        cts_last <= cts_pin;
        if (!rst_b || cts_pin != cts_last)
            cts_quiet <= 4'h0;
        else if (cts_quiet != 4'hf)
            cts_quiet <= cts_quiet + 4'h1;
    end
    chk_pin_masked: assert property (en == 8'h00 |-> irq_b)
        else $error("pin low with all enables off");
    chk_special_pin: assert property (en == 8'h02 && spc |-> !irq_b)
        else $error("special cause did not drive the pin");
    chk_read_drop: assert property (rd2 && en == 8'h02 && !spc |-> irq_b)
        else $error("pin still low in summary read cycle");
    chk_cts_change: assert property (
        $changed(cts_pin) && en == 8'h80 |-> ##[1:6] !irq_b)
        else $error("pin edge not flagged in time");
    chk_word_flags: assert property (
        rd4 && !rhr_read && !$past(rhr_read) && $past(rhr_read, 2)
        |=> reg_rdata[5:2] == $past(rhr_status, 3))
        else $error("line flags differ from last word read");
    chk_overrun_set: assert property (
        rd4 && !rhr_read && !$past(rhr_read)
        && $past(rx_char_valid && rx_fifo_full, 2) |=> reg_rdata[1])
        else $error("overrun flag missing");
    chk_enable_read: assert property (rd3 |=> reg_rdata[7:6] == 2'b00)
        else $error("unused enable bits read nonzero");
    chk_cts_level: assert property (
        rd4 && cts_quiet > 4'h5 |=> reg_rdata[7] == $past(cts_pin))
        else $error("status bit 7 differs from pin level");
    cover property (rd2 && !irq_b);
    cover property (rx_char_valid && rx_fifo_full);
    cover property (rhr_read && rhr_status.brk);
endmodule

// ==== bench/uis_host_model.sv ====
/* Host controller model: reads and writes on the register port.
   Assumes one-cycle strobes, read data valid one cycle later. */
`timescale 1ns/1ps
module uis_host_model (
    input wire logic sys_clk,
    output logic [7:0] reg_addr,
    output logic reg_rd,
    output logic reg_wr,
    output logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata
);
    // Idle port from time zero
    initial {reg_addr, reg_rd, reg_wr, reg_wdata} = '0;
    // Data is taken just after the edge that follows the strobe edge
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
endmodule

// ==== bench/uis_irq_line_status_bench.sv ====
/* Self-checking bench for the interrupt summary and line status block.
   Host model owns the register port; the bench drives the rest. */
`timescale 1ns/1ps
module uis_irq_line_status_bench;
    logic sys_clk = 1'b0;
    logic rst_b = 1'b0;
    logic reg_rd, reg_wr, irq_b, cts_pin, rx_char_valid, rx_fifo_full;
    logic rhr_read, stale_tick;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, rx_fifo_level;
    logic [7:0] tx_fifo_level, stale_data_limit, fifo_level_thresholds;
    logic [7:0] secondary_mode_control, irq_out_enable_reg;
    logic [7:0] status_source_reg, status_route_enable;
    logic [5:0] special_char_cause_reg, special_char_route_enable;
    uis_pkg::uis_char_status_t rhr_status;
    int errors = 0;
    int compares = 0;
    uis_irq_line_status dut (.*);
    uis_host_model host (.*);
    always #25 sys_clk = ~sys_clk;
    task automatic end_of_test();
        if (errors == 0 && compares > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        compares++;
        if (g !== e) begin
            errors++;
            $display("[FAIL] %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] v;
        host.rd(a, v);
        chk(v, e);
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    // One word leaves the receive FIFO carrying the given status
    task automatic pop(input logic [3:0] s);
        @(posedge sys_clk);
        rhr_status <= uis_pkg::uis_char_status_t'(s);
        rhr_read <= 1'b1;
        @(posedge sys_clk);
        rhr_read <= 1'b0;
    endtask
    task automatic t_regs();
        rd(8'h03, 8'h00);
        host.wr(8'h03, 8'hff);
        rd(8'h03, 8'h3f);
        host.wr(8'h04, 8'hff);
        rd(8'h04, 8'h80);
        rd(8'h09, 8'h00);
        host.wr(8'h03, 8'h00);
    endtask
    // Each flag alone, read twice, then a clean word and an overrun
    task automatic t_lsr();
        for (int i = 0; i < 4; i++) begin
            pop(4'h1 << i);
            rd(8'h04, 8'h80 | (8'h04 << i));
            rd(8'h04, 8'h80 | (8'h04 << i));
        end
        pop(4'h0);
        rd(8'h04, 8'h80);
        rx_char_valid <= 1'b1;
        rx_fifo_full <= 1'b1;
        cyc(1);
        rx_char_valid <= 1'b0;
        rx_fifo_full <= 1'b0;
        rd(8'h04, 8'h82);
        pop(4'h0);
        rd(8'h04, 8'h80);
    endtask
    task automatic t_summary();
        pop(4'h8);
        rd(8'h02, 8'h00);
        host.wr(8'h03, 8'h20);
        irq_out_enable_reg <= 8'h01;
        cyc(2);
        chk({7'h0, irq_b}, 8'h00);
        irq_out_enable_reg <= 8'h00;
        cyc(2);
        chk({7'h0, irq_b}, 8'h01);
        rd(8'h02, 8'h01);
        pop(4'h0);
        rd(8'h02, 8'h01);
        rd(8'h02, 8'h00);
        special_char_cause_reg <= 6'h10;
        irq_out_enable_reg <= 8'h02;
        rd(8'h02, 8'h00);
        special_char_route_enable <= 6'h10;
        {status_source_reg, status_route_enable} <= 16'h0101;
        cyc(2);
        chk({7'h0, irq_b}, 8'h00);
        {special_char_cause_reg, status_source_reg} <= 14'h0000;
        cyc(2);
        rd(8'h02, 8'h06);
        rd(8'h02, 8'h00);
        irq_out_enable_reg <= 8'h00;
    endtask
    task automatic t_fifo();
        rx_fifo_level <= 8'h00;
        rd(8'h02, 8'h40);
        secondary_mode_control <= 8'h08;
        rd(8'h02, 8'h40);
        rd(8'h02, 8'h00);
        rx_fifo_level <= 8'h01;
        rd(8'h02, 8'h40);
        secondary_mode_control <= 8'h00;
        rd(8'h02, 8'h40);
        {fifo_level_thresholds, rx_fifo_level} <= 16'h3f03;
        rd(8'h02, 8'h08);
        rd(8'h02, 8'h00);
        secondary_mode_control <= 8'h04;
        rd(8'h02, 8'h00);
        rx_fifo_level <= 8'h01;
        rd(8'h02, 8'h08);
        {fifo_level_thresholds, secondary_mode_control} <= 16'hf400;
        {tx_fifo_level, irq_out_enable_reg} <= 16'h0510;
        cyc(2);
        chk({7'h0, irq_b}, 8'h00);
        tx_fifo_level <= 8'h02;
        cyc(2);
        rd(8'h02, 8'h00);
        tx_fifo_level <= 8'h00;
        rd(8'h02, 8'h20);
        rd(8'h02, 8'h00);
        rd(8'h02, 8'h00);
        {fifo_level_thresholds, irq_out_enable_reg} <= 16'hff80;
    endtask
    // Both pin edges flag a change; the level follows the pin
    task automatic t_cts();
        for (int i = 0; i < 2; i++) begin
            cts_pin <= ~cts_pin;
            cyc(8);
            chk({7'h0, irq_b}, 8'h00);
            rd(8'h02, 8'h80);
            rd(8'h04, {cts_pin, 7'h00});
        end
        irq_out_enable_reg <= 8'h00;
    endtask
    task automatic t_stale(input int n, input logic [7:0] e);
        repeat (n) begin
            stale_tick <= 1'b1;
            cyc(1);
            stale_tick <= 1'b0;
            cyc(1);
        end
        rd(8'h04, e);
    endtask
    // Watchdog far beyond the expected run length
    initial begin
        #200us;
        errors++;
        end_of_test();
    end
    initial begin
        {cts_pin, rx_char_valid, rx_fifo_full, rhr_read, stale_tick} = 5'h10;
        {rx_fifo_level, tx_fifo_level, stale_data_limit} = 24'h010000;
        {fifo_level_thresholds, secondary_mode_control} = 16'hff00;
        {irq_out_enable_reg, status_source_reg, status_route_enable} = '0;
        {special_char_cause_reg, special_char_route_enable, rhr_status} = '0;
        cyc(4);
        rst_b <= 1'b1;
        cyc(6);
        t_regs();
        t_lsr();
        t_summary();
        t_fifo();
        t_cts();
        stale_data_limit <= 8'h03;
        pop(4'h0);
        t_stale(3, 8'h80);
        t_stale(1, 8'h81);
        pop(4'h0);
        stale_data_limit <= 8'h00;
        t_stale(6, 8'h80);
        end_of_test();
    end
endmodule
bind uis_irq_line_status uis_irq_monitor mon (.*);
